/* raster_timing_regs.vh */
`ifndef RASTER_TIMING_REGS_VH
`define RASTER_TIMING_REGS_VH
// register byte offsets, pipes a, b and c
`define PIPE_A_HORIZONTAL_BLANKING_WINDOW_OFS 20'h60004
`define PIPE_A_HSYNC_OFS 20'h60008
`define PIPE_A_VERTICAL_FRAME_SIZE_OFS 20'h6000c
`define PIPE_B_HORIZONTAL_BLANKING_WINDOW_OFS 20'h61004
`define PIPE_B_HSYNC_OFS 20'h61008
`define PIPE_B_VERTICAL_FRAME_SIZE_OFS 20'h6100c
`define PIPE_C_HORIZONTAL_BLANKING_WINDOW_OFS 20'h62004
`define PIPE_C_HSYNC_OFS 20'h62008
`define PIPE_C_VERTICAL_FRAME_SIZE_OFS 20'h6200c
// spacing between pipe register blocks
`define PIPE_STRIDE 20'h01000
// field positions
`define END_FIELD_MSB 28
`define END_FIELD_LSB 16
`define START_FIELD_MSB 12
`define START_FIELD_LSB 0
`define VACT_FIELD_MSB 11
`define VACT_FIELD_LSB 0
// reset values and write masks
`define TIMING_RESET 32'h00000000
`define POS_WMASK 32'h1fff1fff
`define VTOT_WMASK 32'h1fff0fff
`endif

/* pipe_raster_core.v */
`timescale 1ns/10ps
`include "raster_timing_regs.vh"
module pipe_raster_core
(
  input wire clk_sys,
  input wire nrst,
  input wire enable,
  input wire interlaced,
  input wire [31:0] horizontal_blanking_window_reg,
  input wire [31:0] hsync_reg,
  input wire [31:0] vertical_frame_size_reg,
  input wire [12:0] vsync_start,
  input wire [12:0] vsync_end,
  output reg horizontal_blanking_window_q,
  output reg hsync_q,
  output reg vertical_blanking_window_q,
  output reg vsync_q,
  output reg field_q,
  output reg [12:0] hcount_q,
  output reg [12:0] vcount_q
);
  wire [12:0] h_total;
  wire [12:0] h_bl_start;
  wire [12:0] hs_start;
  wire [12:0] hs_end;
  wire [12:0] v_total;
  wire [11:0] v_active;
  wire [12:0] v_last;
  wire [12:0] va_last;
  wire [12:0] hcount_d;
  wire [12:0] vcount_d;
  wire line_end;
  wire hsync_lead;
  wire hsync_d;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  // blank end equals the horizontal total, so it sets the line length
  assign h_total = horizontal_blanking_window_reg[`END_FIELD_MSB:`END_FIELD_LSB];
  assign h_bl_start = horizontal_blanking_window_reg[`START_FIELD_MSB:`START_FIELD_LSB];
  assign hs_start = hsync_reg[`START_FIELD_MSB:`START_FIELD_LSB];
  assign hs_end = hsync_reg[`END_FIELD_MSB:`END_FIELD_LSB];
  assign v_total = vertical_frame_size_reg[`END_FIELD_MSB:`END_FIELD_LSB];
  assign v_active = vertical_frame_size_reg[`VACT_FIELD_MSB:`VACT_FIELD_LSB];
  // interlace: total is lines-2, so fields hold (t+2)/2 lines each;
  // an odd sum gives field 0 the extra line, even and odd both work
  assign v_last = interlaced ?
    (field_q ? ((v_total + 13'h0002) >> 1) - 13'h0001
             : ((v_total + 13'h0003) >> 1) - 13'h0001) : v_total;
  // active lines per field derived from one programmed value
  assign va_last = interlaced ?
    (field_q ? ({1'b0, v_active} >> 1) - 13'h0001 + 13'h0000
             : ({1'b0, v_active} + 13'h0001) >> 1) - 13'h0000 :
    {1'b0, v_active};

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  // pixel counter wraps once it reaches the horizontal total
  assign line_end = (hcount_q >= h_total);
  assign hcount_d = line_end ? 13'h0000 : hcount_q + 13'h0001;
  assign hsync_d = (hcount_d >= hs_start) && (hcount_d <= hs_end);
  // lines advance at hsync leading edge, not at the line wrap
  assign hsync_lead = hsync_d && !hsync_q;
  assign vcount_d = (vcount_q >= v_last) ? 13'h0000 : vcount_q + 13'h0001;

  // pixel and line state, all cleared while the pipe is off
  always @(posedge clk_sys)
  begin
    if (!nrst || !enable)
    begin
      hcount_q <= 13'h0000;
      vcount_q <= 13'h0000;
      horizontal_blanking_window_q <= 1'b0;
      hsync_q <= 1'b0;
      vertical_blanking_window_q <= 1'b0;
      vsync_q <= 1'b0;
      field_q <= 1'b0;
    end
    else
    begin
      hcount_q <= hcount_d;
      hsync_q <= hsync_d;
      horizontal_blanking_window_q <= (hcount_d >= h_bl_start) && (hcount_d <= h_total);
      if (hsync_lead)
      begin
        vcount_q <= vcount_d;
        // first active line is line zero
        vertical_blanking_window_q <= (vcount_d > va_last) && (vcount_d <= v_last);
        vsync_q <= (vcount_d >= vsync_start) && (vcount_d <= vsync_end);
        if (vcount_q >= v_last && interlaced)
          field_q <= !field_q;
      end
    end
  end
endmodule

/* pipe_raster_timing_generator.v */
`timescale 1ns/10ps
`include "raster_timing_regs.vh"
module pipe_raster_timing_generator
(
  input wire clk_sys,
  input wire nrst,
  input wire [19:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_q,
  input wire [2:0] pipe_enable,
  input wire [2:0] pipe_interlaced,
  input wire [38:0] vsync_start,
  input wire [38:0] vsync_end,
  output wire [2:0] horizontal_blanking_window,
  output wire [2:0] hsync,
  output wire [2:0] vertical_blanking_window,
  output wire [2:0] vsync,
  output wire [2:0] field,
  output wire [38:0] hcount,
  output wire [38:0] vcount
);
  reg [31:0] horizontal_blanking_window_q [0:2];
  reg [31:0] hsync_q [0:2];
  reg [31:0] vertical_frame_size_q [0:2];
  reg [31:0] rdata_d;
  integer i;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // reserved bits are masked on write so they always read zero
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        horizontal_blanking_window_q[i] <= `TIMING_RESET;
        hsync_q[i] <= `TIMING_RESET;
        vertical_frame_size_q[i] <= `TIMING_RESET;
      end
    end
    else if (reg_wr)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        if (reg_addr == `PIPE_A_HORIZONTAL_BLANKING_WINDOW_OFS + i[19:0] * `PIPE_STRIDE)
          horizontal_blanking_window_q[i] <= reg_wdata & `POS_WMASK;
        if (reg_addr == `PIPE_A_HSYNC_OFS + i[19:0] * `PIPE_STRIDE)
          hsync_q[i] <= reg_wdata & `POS_WMASK;
        if (reg_addr == `PIPE_A_VERTICAL_FRAME_SIZE_OFS + i[19:0] * `PIPE_STRIDE)
          vertical_frame_size_q[i] <= reg_wdata & `VTOT_WMASK;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    case (reg_addr)
      `PIPE_A_HORIZONTAL_BLANKING_WINDOW_OFS: rdata_d = horizontal_blanking_window_q[0];
      `PIPE_A_HSYNC_OFS: rdata_d = hsync_q[0];
      `PIPE_A_VERTICAL_FRAME_SIZE_OFS: rdata_d = vertical_frame_size_q[0];
      `PIPE_B_HORIZONTAL_BLANKING_WINDOW_OFS: rdata_d = horizontal_blanking_window_q[1];
      `PIPE_B_HSYNC_OFS: rdata_d = hsync_q[1];
      `PIPE_B_VERTICAL_FRAME_SIZE_OFS: rdata_d = vertical_frame_size_q[1];
      `PIPE_C_HORIZONTAL_BLANKING_WINDOW_OFS: rdata_d = horizontal_blanking_window_q[2];
      `PIPE_C_HSYNC_OFS: rdata_d = hsync_q[2];
      `PIPE_C_VERTICAL_FRAME_SIZE_OFS: rdata_d = vertical_frame_size_q[2];
      default: rdata_d = 32'h00000000;
    endcase
  end

  // read data registered, valid the cycle after reg_rd
  always @(posedge clk_sys)
  begin
    if (!nrst)
      reg_rdata_q <= 32'h00000000;
    else if (reg_rd)
      reg_rdata_q <= rdata_d;
  end

  // ---------------------------------------------------------------
  // one timing core per pipe
  // ---------------------------------------------------------------
  // registers are live, not double buffered: reprogram with pipe off
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : pipe
      pipe_raster_core u_core
      (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .enable(pipe_enable[g]),
        .interlaced(pipe_interlaced[g]),
        .horizontal_blanking_window_reg(horizontal_blanking_window_q[g]),
        .hsync_reg(hsync_q[g]),
        .vertical_frame_size_reg(vertical_frame_size_q[g]),
        .vsync_start(vsync_start[g*13 +: 13]),
        .vsync_end(vsync_end[g*13 +: 13]),
        .horizontal_blanking_window_q(horizontal_blanking_window[g]),
        .hsync_q(hsync[g]),
        .vertical_blanking_window_q(vertical_blanking_window[g]),
        .vsync_q(vsync[g]),
        .field_q(field[g]),
        .hcount_q(hcount[g*13 +: 13]),
        .vcount_q(vcount[g*13 +: 13])
      );
    end
  endgenerate
endmodule

/* panel_model.sv */
`timescale 1ns/10ps
module panel_model
(
  input wire clk_sys,
  input wire hsync,
  input wire [12:0] vcount,
  output reg [12:0] lines_q
);
  reg [12:0] cnt_q = 13'h0;
  reg hs_q = 1'b0;
  // count sync pulses between returns of the line number to zero
  always @(posedge clk_sys)
  begin
    hs_q <= hsync;
    if (hsync && !hs_q)
    begin
      cnt_q <= (vcount == 13'h0) ? 13'h1 : cnt_q + 13'h1;
      if (vcount == 13'h0)
        lines_q <= cnt_q;
    end
  end
endmodule

/* raster_timing_props.sv */
`timescale 1ns/10ps
`include "raster_timing_regs.vh"
module raster_timing_props
(
  input wire clk_sys,
  input wire nrst,
  input wire [19:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata_q,
  input wire [2:0] pipe_enable,
  input wire [2:0] pipe_interlaced,
  input wire [2:0] horizontal_blanking_window,
  input wire [2:0] hsync,
  input wire [2:0] vertical_blanking_window,
  input wire [2:0] vsync,
  input wire [38:0] vsync_start,
  input wire [38:0] vsync_end,
  input wire [2:0] field,
  input wire [38:0] hcount,
  input wire [38:0] vcount
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  reg [31:0] hb_q, hs_q, vt_q;
  reg [1:0] en_q;
  wire run = pipe_enable[0] & en_q[0] & en_q[1];
  wire [12:0] hc = hcount[12:0];
  wire [12:0] vc = vcount[12:0];
  // pipe a shadow; windows trusted only after three enabled edges
  always @(posedge clk_sys)
  begin
    en_q <= nrst ? {en_q[0], pipe_enable[0]} : 2'h0;
    if (!nrst)
    begin
      hb_q <= 32'h0;
      hs_q <= 32'h0;
      vt_q <= 32'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `PIPE_A_HORIZONTAL_BLANKING_WINDOW_OFS)
        hb_q <= reg_wdata & `POS_WMASK;
      if (reg_addr == `PIPE_A_HSYNC_OFS)
        hs_q <= reg_wdata & `POS_WMASK;
      if (reg_addr == `PIPE_A_VERTICAL_FRAME_SIZE_OFS)
        vt_q <= reg_wdata & `VTOT_WMASK;
    end
  end
  sequence s_new_frame;
    $rose(hsync[0]) && vc == 13'h0;
  endsequence
  chk_blank_readback: assert property (
    reg_rd && reg_addr == `PIPE_A_HORIZONTAL_BLANKING_WINDOW_OFS |=> reg_rdata_q == $past(hb_q))
    else $error("readback");
  chk_blank_window: assert property (
    run |-> horizontal_blanking_window[0] == (hc >= hb_q[12:0] && hc <= hb_q[28:16])) else $error("blank");
  chk_sync_window: assert property (
    run |-> hsync[0] == (hc >= hs_q[12:0] && hc <= hs_q[28:16])) else $error("sync");
  chk_pixel_step: assert property (
    run && hc != 13'h0 |-> hc == $past(hc) + 13'h1) else $error("pixel");
  chk_line_step: assert property (
    run |-> $changed(vc) == $rose(hsync[0])) else $error("line");
  chk_vertical_blanking_window_window: assert property (
    run && !pipe_interlaced[0] |-> vertical_blanking_window[0] == (vc > {1'b0, vt_q[11:0]} && vc <= vt_q[28:16]))
    else $error("vertical_blanking_window");
  chk_field_flip: assert property (
    run && $changed(field[0]) |-> s_new_frame) else $error("field");
  // vsync follows the line number, moving only with it
  chk_vsync_window: assert property (
    run |-> vsync[0] == (vc >= vsync_start[12:0] && vc <= vsync_end[12:0])) else $error("vsync");
endmodule
bind pipe_raster_timing_generator raster_timing_props u_props (.clk_sys, .nrst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .pipe_enable, .pipe_interlaced, .horizontal_blanking_window, .hsync,
  .vertical_blanking_window, .vsync, .vsync_start, .vsync_end, .field, .hcount, .vcount);

/* tb.sv */
`timescale 1ns/10ps
module tb;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg [19:0] reg_addr = 20'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [31:0] reg_wdata = 32'h0;
  reg [2:0] pipe_enable = 3'h0;
  reg [2:0] pipe_interlaced = 3'h0;
  reg [38:0] vsync_start = 39'h0;
  reg [38:0] vsync_end = 39'h0;
  wire [31:0] reg_rdata_q;
  wire [2:0] horizontal_blanking_window, hsync, vertical_blanking_window, vsync, field;
  wire [38:0] hcount, vcount;
  wire [12:0] lines;
  reg [31:0] lfsr = 32'h9956;
  reg [31:0] w;
  reg fb;
  int n_fail = 0;
  int samples_checked = 0;
  int i, t, a;
  always #5 clk_sys = ~clk_sys;
  pipe_raster_timing_generator DUT (.clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .pipe_enable, .pipe_interlaced, .vsync_start, .vsync_end, .horizontal_blanking_window, .hsync,
    .vertical_blanking_window, .vsync, .field, .hcount, .vcount);
  panel_model u_panel (.clk_sys, .hsync(hsync[0]), .vcount(vcount[12:0]), .lines_q(lines));
  // fixed seed keeps every run repeatable
  function [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function [19:0] ofs(int n);
    return 20'(32'h60004 + 32'h1000 * (n / 3) + 4 * (n % 3));
  endfunction
  task tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task end_of_test();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes drop one edge before the next request may rise
  task wr(logic [19:0] ad, logic [31:0] d);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task rd(logic [19:0] ad, logic [31:0] exp);
    reg_addr = ad;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    cmp(reg_rdata_q, exp);
    tick(1);
  endtask
  task wait_field();
    for (a = 0; a < 6000 && field[0] === fb; a++)
      tick(1);
    if (a == 6000)
    begin
      n_fail++;
      end_of_test();
    end
    fb = field[0];
    tick(2);
  endtask
  initial
  begin
    tick(20);
    nrst = 1'b1;
    for (i = 0; i < 9; i++)
      rd(ofs(i), 32'h0);
    wr(20'h60000, rnd());
    rd(20'h60000, 32'h0);
    for (i = 0; i < 9; i++)
    begin
      w = rnd();
      wr(ofs(i), w);
      rd(ofs(i), w & ((i % 3 == 2) ? 32'h1fff0fff : 32'h1fff1fff));
    end
    $display("registers done");
    // pipe a: 64 active, blank to 99, sync 69..79; b and c keep random setups
    wr(ofs(0), {3'h0, 13'd99, 3'h0, 13'd64});
    wr(ofs(1), {3'h0, 13'd79, 3'h0, 13'd69});
    wr(ofs(2), {3'h0, 13'd14, 4'h0, 12'd9});
    w = rnd();
    vsync_start = {w[25:0], 13'd10};
    vsync_end = {~w[25:0], 13'd11};
    pipe_enable = 3'h7;
    tick(4000);
    cmp({19'h0, lines}, 32'd15);
    $display("progressive done");
    // odd and even totals, the two fields together span both halves
    for (t = 14; t < 16; t++)
    begin
      pipe_enable = 3'h0;
      tick(2);
      wr(ofs(2), {3'h0, 13'(t), 4'h0, 12'd9});
      pipe_interlaced = 3'h1;
      pipe_enable = 3'h7;
      fb = field[0];
      wait_field();
      wait_field();
      i = lines;
      wait_field();
      cmp(i + lines, ((t + 3) >> 1) + ((t + 2) >> 1));
    end
    $display("interlaced done");
    end_of_test();
  end
endmodule
